// file: design/bank_address.sv
// Register bank address former for register-form operands
`timescale 1ns/1ps
`default_nettype none
module bank_address
    import core_regs_pkg::*;
(
    // Selection
    input  wire logic [1:0] bank_i,
    input  wire logic [2:0] reg_idx_i,
    // Internal data address
    output logic [7:0]      addr_o
);
    // Bank number times eight plus register number
    assign addr_o = {3'h0, bank_i, reg_idx_i}; // RQ13 RQ4
endmodule
`default_nettype wire

// file: design/core_regs_pkg.sv
// Package with offsets, reset values, field positions and carrier types for the core special registers
package core_regs_pkg;

    // Special function register offsets
    localparam logic [7:0] STACK_TOP_POINTER_ADDR       = 8'h81;
    localparam logic [7:0] DATA_POINTER_LOW_BYTE_ADDR   = 8'h82;
    localparam logic [7:0] DATA_POINTER_HIGH_BYTE_ADDR  = 8'h83;
    localparam logic [7:0] STATUS_WORD_ADDR             = 8'hd0;
    localparam logic [7:0] MAIN_OPERAND_REGISTER_ADDR   = 8'he0;
    localparam logic [7:0] SECOND_OPERAND_REGISTER_ADDR = 8'hf0;

    // Values after reset
    localparam logic [7:0] STACK_TOP_POINTER_RST = 8'h07;
    localparam logic [7:0] ZERO_BYTE_RST         = 8'h00;

    // Status word bit positions
    localparam int CARRY_FLAG_POS     = 7;
    localparam int HALF_CARRY_POS     = 6;
    localparam int USER_FLAG_ZERO_POS = 5;
    localparam int BANK_SELECT_HI_POS = 4;
    localparam int BANK_SELECT_LO_POS = 3;
    localparam int SIGNED_WRAP_POS    = 2;
    localparam int USER_FLAG_ONE_POS  = 1;
    localparam int PARITY_POS         = 0;

    // Bank layout: each bank is eight bytes from address zero
    localparam int BANK_BYTES_LOG2 = 3;

    // Flag updates from the execution datapath
    typedef struct packed {
        logic carry_we;
        logic carry;
        logic half_carry_we;
        logic half_carry;
        logic signed_wrap_we;
        logic signed_wrap;
    } flag_update_type;

    // Register software access (byte or single bit)
    typedef struct packed {
        logic       wr;
        logic       bit_wr;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_access_type;

endpackage

// file: design/cpu_core_special_registers.sv
// Core special registers: status word, stack pointer, data pointer and operand registers
// Summary of operation
// RQ1: Stack pointer pre-increments before every push; a software write to it in the same cycle wins and the push does not increment
// RQ2: Stack pointer resets to seven
// RQ3: Parity flag shows odd ones in operand
// RQ4: Bank select bits choose one of four banks
// RQ5: Low and high bytes form sixteen-bit pointer
// RQ6: Pointer addresses expanded RAM and program flash
// RQ7: Carry serves arithmetic and Boolean bit work
// RQ8: Status word holds datapath-updated flags
// RQ9: Two user flags change by software only
// RQ10: Status word byte and bit accessible
// RQ11: Main operand register is primary arithmetic operand
// RQ12: Second operand register assists multiply, divide
// RQ13: Banks sit at lowest bytes, eight each
// RQ14: Software write beats datapath; parity follows operand
`timescale 1ns/1ps
`default_nettype none
module cpu_core_special_registers
    import core_regs_pkg::*;
(
    // Clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rst_i,
    // Software register access
    input  wire sfr_access_type  sfr_i,
    output logic [7:0]           sfr_rdata_o,
    output logic                 sfr_hit_o,
    input  wire logic [2:0]      sfr_bit_rd_idx_i,
    output logic                 sfr_bit_rdata_o,
    // Datapath: operand registers
    input  wire logic            main_we_i,
    input  wire logic [7:0]      main_wdata_i,
    input  wire logic            second_we_i,
    input  wire logic [7:0]      second_wdata_i,
    // Datapath: flags and Boolean carry
    input  wire flag_update_type flags_i,
    // Datapath: stack
    input  wire logic            push_i,
    input  wire logic            pop_i,
    output logic [7:0]           push_addr_o,
    // Datapath: data pointer
    input  wire logic            ptr_we_i,
    input  wire logic [15:0]     ptr_wdata_i,
    input  wire logic            ptr_inc_i,
    output logic [15:0]          data_pointer_pair_o,
    // Datapath: register bank operand
    input  wire logic [2:0]      reg_idx_i,
    output logic [7:0]           reg_addr_o,
    // Register views
    output logic [7:0]           main_operand_register_o,
    output logic [7:0]           second_operand_register_o,
    output logic [7:0]           status_word_o,
    output logic [7:0]           stack_top_pointer_o,
    output logic                 carry_flag_o
);

    logic [7:0]  stack_top_pointer_q;
    logic [7:0]  data_pointer_low_byte_q;
    logic [7:0]  data_pointer_high_byte_q;
    logic [7:0]  main_operand_register_q;
    logic [7:0]  second_operand_register_q;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic        parity;
    logic [15:0] ptr_next;

    // Merge one bit or a whole byte into a register value
    function automatic logic [7:0] merge_write(input logic [7:0] old, input sfr_access_type req);
        logic [7:0] res;
        res = old;
        if (req.bit_wr) begin
            res[req.bit_idx] = req.wdata[0];
        end else begin
            res = req.wdata;
        end
        return res;
    endfunction

    // Decode a software write to one address
    function automatic logic sw_write(input sfr_access_type req, input logic [7:0] addr);
        return (req.wr || req.bit_wr) && (req.addr == addr);
    endfunction

    // Parity of the operand register
    parity_calc #(
        .WIDTH (8)
    ) u_parity (
        .value_i (main_operand_register_q),
        .odd_o   (parity)
    );

    // Register bank address
    bank_address u_bank (
        .bank_i    (status_q[BANK_SELECT_HI_POS:BANK_SELECT_LO_POS]),
        .reg_idx_i (reg_idx_i),
        .addr_o    (reg_addr_o)
    );

    // Stack pointer: software write wins, push pre-increments, pop post-decrements
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stack_top_pointer_q <= STACK_TOP_POINTER_RST; // RQ2
        end else if (sw_write(sfr_i, STACK_TOP_POINTER_ADDR)) begin
            stack_top_pointer_q <= merge_write(stack_top_pointer_q, sfr_i);
        end else if (push_i) begin
            stack_top_pointer_q <= stack_top_pointer_q + 8'h01; // RQ1
        end else if (pop_i) begin
            stack_top_pointer_q <= stack_top_pointer_q - 8'h01;
        end
    end

    // Address where a push stores its byte: the incremented pointer
    assign push_addr_o = stack_top_pointer_q + 8'h01; // RQ1

    // Data pointer next value from datapath
    assign ptr_next = ptr_we_i ? ptr_wdata_i
                    : (data_pointer_pair_o + 16'h0001);

    // Data pointer low byte
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_pointer_low_byte_q <= ZERO_BYTE_RST;
        end else if (sw_write(sfr_i, DATA_POINTER_LOW_BYTE_ADDR)) begin
            data_pointer_low_byte_q <= merge_write(data_pointer_low_byte_q, sfr_i);
        end else if (ptr_we_i || ptr_inc_i) begin
            data_pointer_low_byte_q <= ptr_next[7:0]; // RQ5
        end
    end

    // Data pointer high byte
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_pointer_high_byte_q <= ZERO_BYTE_RST;
        end else if (sw_write(sfr_i, DATA_POINTER_HIGH_BYTE_ADDR)) begin
            data_pointer_high_byte_q <= merge_write(data_pointer_high_byte_q, sfr_i);
        end else if (ptr_we_i || ptr_inc_i) begin
            data_pointer_high_byte_q <= ptr_next[15:8]; // RQ5
        end
    end

    // Combined pointer for expanded RAM and flash reads
    assign data_pointer_pair_o = {data_pointer_high_byte_q, data_pointer_low_byte_q}; // RQ5 RQ6

    // Main operand register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            main_operand_register_q <= ZERO_BYTE_RST;
        end else if (sw_write(sfr_i, MAIN_OPERAND_REGISTER_ADDR)) begin
            main_operand_register_q <= merge_write(main_operand_register_q, sfr_i); // RQ11
        end else if (main_we_i) begin
            main_operand_register_q <= main_wdata_i; // RQ11
        end
    end

    // Second operand register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            second_operand_register_q <= ZERO_BYTE_RST;
        end else if (sw_write(sfr_i, SECOND_OPERAND_REGISTER_ADDR)) begin
            second_operand_register_q <= merge_write(second_operand_register_q, sfr_i);
        end else if (second_we_i) begin
            second_operand_register_q <= second_wdata_i; // RQ12
        end
    end

    // Status word next value: datapath flags, then software write over them
    always_comb begin
        status_d = status_q;
        if (flags_i.carry_we) begin
            status_d[CARRY_FLAG_POS] = flags_i.carry; // RQ7 RQ8
        end
        if (flags_i.half_carry_we) begin
            status_d[HALF_CARRY_POS] = flags_i.half_carry; // RQ8
        end
        if (flags_i.signed_wrap_we) begin
            status_d[SIGNED_WRAP_POS] = flags_i.signed_wrap; // RQ8
        end
        if (sw_write(sfr_i, STATUS_WORD_ADDR)) begin
            status_d = merge_write(status_d, sfr_i); // RQ10 RQ14 RQ9
        end
        status_d[PARITY_POS] = 1'b0;
    end

    // Status word storage (parity bit is not stored)
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_q <= ZERO_BYTE_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Status word view with live parity
    assign status_word_o = {status_q[7:1], parity}; // RQ3 RQ14

    // Software read mux
    always_comb begin
        sfr_hit_o   = 1'b1;
        sfr_rdata_o = 8'h00;
        case (sfr_i.addr)
            STACK_TOP_POINTER_ADDR:       sfr_rdata_o = stack_top_pointer_q;
            DATA_POINTER_LOW_BYTE_ADDR:   sfr_rdata_o = data_pointer_low_byte_q;
            DATA_POINTER_HIGH_BYTE_ADDR:  sfr_rdata_o = data_pointer_high_byte_q;
            STATUS_WORD_ADDR:             sfr_rdata_o = status_word_o; // RQ10
            MAIN_OPERAND_REGISTER_ADDR:   sfr_rdata_o = main_operand_register_q;
            SECOND_OPERAND_REGISTER_ADDR: sfr_rdata_o = second_operand_register_q;
            default:                      sfr_hit_o = 1'b0;
        endcase
    end

    // Bit read of the addressed register
    assign sfr_bit_rdata_o = sfr_rdata_o[sfr_bit_rd_idx_i]; // RQ10

    // Register views
    assign main_operand_register_o   = main_operand_register_q;
    assign second_operand_register_o = second_operand_register_q;
    assign stack_top_pointer_o       = stack_top_pointer_q;
    assign carry_flag_o              = status_q[CARRY_FLAG_POS]; // RQ7

    // Assertions
    sequence push_only_s;
        push_i && !sw_write(sfr_i, STACK_TOP_POINTER_ADDR);
    endsequence

    stack_push_inc_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ1
        push_only_s |=> stack_top_pointer_q == $past(stack_top_pointer_q) + 8'h01)
        else $error("stack pointer did not increment on push");

    stack_reset_a: assert property (@(posedge mclk_i) // RQ2
        rst_i |=> stack_top_pointer_q == 8'h07)
        else $error("stack pointer not seven after reset");

    parity_track_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ3
        status_word_o[0] == ^main_operand_register_o)
        else $error("parity does not follow operand register");

    bank_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ4
        reg_addr_o == {3'h0, status_word_o[4:3], reg_idx_i})
        else $error("bank address wrong");

    ptr_pair_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ5
        ptr_we_i && !sfr_i.wr && !sfr_i.bit_wr |=> data_pointer_pair_o == $past(ptr_wdata_i))
        else $error("data pointer load lost");

    carry_update_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ7
        flags_i.carry_we && !sw_write(sfr_i, STATUS_WORD_ADDR) |=> carry_flag_o == $past(flags_i.carry))
        else $error("carry not updated");

    user_flags_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ9
        !sw_write(sfr_i, STATUS_WORD_ADDR) |=> $stable({status_word_o[5], status_word_o[1]}))
        else $error("user flags changed without software");

    sw_wins_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ14
        sfr_i.wr && !sfr_i.bit_wr && sfr_i.addr == STATUS_WORD_ADDR
        |=> status_word_o[7:1] == $past(sfr_i.wdata[7:1]))
        else $error("software status write did not win");

    second_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ12
        second_we_i && !sw_write(sfr_i, SECOND_OPERAND_REGISTER_ADDR)
        |=> second_operand_register_o == $past(second_wdata_i))
        else $error("second operand load lost");

    sequence main_load_only_s;
        main_we_i && !sw_write(sfr_i, MAIN_OPERAND_REGISTER_ADDR);
    endsequence

    sequence ptr_inc_only_s;
        ptr_inc_i && !ptr_we_i && !sfr_i.wr && !sfr_i.bit_wr;
    endsequence

    push_lands_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ1
        push_only_s |=> stack_top_pointer_o == $past(push_addr_o))
        else $error("pushed byte address is not the new stack top");

    main_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ11
        main_load_only_s |=> main_operand_register_o == $past(main_wdata_i))
        else $error("main operand load lost");

    parity_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ3
        main_load_only_s |=> status_word_o[PARITY_POS] == ^$past(main_wdata_i))
        else $error("parity does not match loaded operand");

    ptr_inc_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ5
        ptr_inc_only_s |=> data_pointer_pair_o == $past(data_pointer_pair_o) + 16'h0001)
        else $error("data pointer increment wrong");

    ptr_low_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ5
        sfr_i.wr && !sfr_i.bit_wr && sfr_i.addr == DATA_POINTER_LOW_BYTE_ADDR
        |=> data_pointer_pair_o[7:0] == $past(sfr_i.wdata))
        else $error("low pointer byte not in bits 7 to 0");

    ptr_high_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ5
        sfr_i.wr && !sfr_i.bit_wr && sfr_i.addr == DATA_POINTER_HIGH_BYTE_ADDR
        |=> data_pointer_pair_o[15:8] == $past(sfr_i.wdata))
        else $error("high pointer byte not in bits 15 to 8");

    half_carry_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ8
        flags_i.half_carry_we && !sw_write(sfr_i, STATUS_WORD_ADDR)
        |=> status_word_o[HALF_CARRY_POS] == $past(flags_i.half_carry))
        else $error("half carry not updated");

    wrap_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ8
        flags_i.signed_wrap_we && !sw_write(sfr_i, STATUS_WORD_ADDR)
        |=> status_word_o[SIGNED_WRAP_POS] == $past(flags_i.signed_wrap))
        else $error("signed wrap flag not updated");

    status_read_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ10
        sfr_i.addr == STATUS_WORD_ADDR |-> sfr_hit_o && sfr_rdata_o == status_word_o)
        else $error("status word read wrong");

endmodule
`default_nettype wire

// file: design/parity_calc.sv
// Even-parity tracker for the main operand register
`timescale 1ns/1ps
`default_nettype none
module parity_calc
    import core_regs_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Value in
    input  wire logic [WIDTH-1:0] value_i,
    // Parity out
    output logic                  odd_o
);
    // Refuse a width that leaves nothing to check
    if (WIDTH < 1) begin : g_width_check
        $error("parity_calc: WIDTH must be positive");
    end

    // One when the count of one bits is odd
    assign odd_o = ^value_i; // RQ3
endmodule
`default_nettype wire

// file: tb/exec_path_model.sv
// Behavioural model of the execution datapath driving the core registers
`timescale 1ns/1ps
`default_nettype none
module exec_path_model
    import core_regs_pkg::*;
(
    // Clock
    input  wire logic           mclk_i,
    // Register update requests
    output var logic            main_we_o,
    output var logic            second_we_o,
    output var logic [7:0]      main_wdata_o,
    output var logic [7:0]      second_wdata_o,
    output var flag_update_type flags_o,
    output var logic            push_o,
    output var logic            pop_o,
    output var logic            ptr_we_o,
    output var logic            ptr_inc_o,
    output var logic [15:0]     ptr_wdata_o
);
    // Idle from time zero
    initial begin
        {main_we_o, second_we_o, push_o, pop_o, ptr_we_o, ptr_inc_o} = 6'h00;
        {main_wdata_o, second_wdata_o, flags_o, ptr_wdata_o} = 38'h0;
    end
    // One-cycle request; afterwards data shows its inverse so nothing stale lingers
    task automatic step(input logic [5:0] req, input logic [7:0] v, input flag_update_type f,
                        input logic [15:0] d);
        @(posedge mclk_i);
        {main_we_o, second_we_o, push_o, pop_o, ptr_we_o, ptr_inc_o} <= req;
        {main_wdata_o, second_wdata_o, flags_o, ptr_wdata_o} <= {v, v, f, d};
        @(posedge mclk_i);
        {main_we_o, second_we_o, push_o, pop_o, ptr_we_o, ptr_inc_o} <= 6'h00;
        {main_wdata_o, second_wdata_o, ptr_wdata_o} <= {~v, ~v, ~d};
        flags_o <= ~f & 6'h15;
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking testbench for the core special register block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import core_regs_pkg::*;
;
    // Stimulus, results and bookkeeping
    logic            mclk_i;
    logic            rst_i = 1'b1;
    sfr_access_type  sfr_i = '0;
    logic [2:0]      sfr_bit_rd_idx_i = 3'h0;
    logic [2:0]      reg_idx_i = 3'h0;
    wire logic       main_we_i, second_we_i, push_i, pop_i, ptr_we_i, ptr_inc_i, hit, bdat, cfl;
    wire logic [7:0] main_wdata_i, second_wdata_i, rdat, padr, radr, mop, sec, sw, stk;
    wire logic [15:0] ptr_wdata_i, dp;
    wire flag_update_type flags_i;
    int              mismatches = 0;
    int              n_compared = 0;
    int              cycles = 0;
    logic [7:0]      adr [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
    logic [7:0]      wv [6] = '{8'h20, 8'h34, 8'h12, 8'hff, 8'h03, 8'hc3};
    logic [7:0]      pv [6] = '{8'h00, 8'h01, 8'h07, 8'h80, 8'hff, 8'hfe};

    // Datapath model
    exec_path_model model_u (
        .mclk_i, .main_we_o(main_we_i), .main_wdata_o(main_wdata_i), .second_we_o(second_we_i),
        .second_wdata_o(second_wdata_i), .flags_o(flags_i), .push_o(push_i), .pop_o(pop_i),
        .ptr_we_o(ptr_we_i), .ptr_wdata_o(ptr_wdata_i), .ptr_inc_o(ptr_inc_i)
    );
    // Block under test
    cpu_core_special_registers dut_u (
        .mclk_i, .rst_i, .sfr_i, .sfr_rdata_o(rdat), .sfr_hit_o(hit), .sfr_bit_rd_idx_i,
        .sfr_bit_rdata_o(bdat), .main_we_i, .main_wdata_i, .second_we_i, .second_wdata_i, .flags_i,
        .push_i, .pop_i, .push_addr_o(padr), .ptr_we_i, .ptr_wdata_i, .ptr_inc_i,
        .data_pointer_pair_o(dp), .reg_idx_i, .reg_addr_o(radr), .main_operand_register_o(mop),
        .second_operand_register_o(sec), .status_word_o(sw), .stack_top_pointer_o(stk),
        .carry_flag_o(cfl)
    );

    // Clock at 4 ns
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // Hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_sim();
        end
    end

    // Verdict and end of run
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    // Byte write (mode = 0) or bit write of d[0] (mode[3] set, mode[2:0] bit)
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] mode);
        @(posedge mclk_i);
        sfr_i <= '{wr: !mode[3], bit_wr: mode[3], bit_idx: mode[2:0], addr: a, wdata: d};
        @(posedge mclk_i);
        sfr_i <= '{wr: 1'b0, bit_wr: 1'b0, bit_idx: mode[2:0], addr: a, wdata: ~d};
    endtask
    // Read and compare one register
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        sfr_i.addr <= a;
        #1;
        chk(rdat, e, "read");
        chk(hit, 1'b1, "hit");
    endtask

    // Test sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rd(adr[i], (i == 0) ? 8'h07 : 8'h00);
        chk(stk, 8'h07, "stack after reset");
        @(posedge mclk_i);
        sfr_i.addr <= 8'h80;
        #1;
        chk({rdat, 7'h0, hit}, 16'h0, "unmapped");
        $display("reset test done");
        for (int i = 0; i < 6; i++) wr(adr[i], wv[i], 4'h0);
        for (int i = 0; i < 6; i++) rd(adr[i], (i == 3) ? 8'hfe : wv[i]);
        chk(dp, 16'h1234, "pointer pair");
        $display("software access test done");
        for (int i = 0; i < 6; i++) begin
            model_u.step(6'h20, pv[i], 6'h0, 16'h0);
            #1;
            chk({mop, 7'h0, sw[0]}, {pv[i], 7'h0, ^pv[i]}, "parity");
        end
        model_u.step(6'h10, 8'h9c, 6'h0, 16'h0);
        #1;
        chk({sec, mop}, 16'h9cfe, "second operand");
        fork
            model_u.step(6'h10, 8'h11, 6'h0, 16'h0);
            wr(8'hf0, 8'h22, 4'h0);
        join
        #1;
        chk(sec, 8'h22, "second collision");
        $display("operand test done");
        wr(8'hd0, 8'h00, 4'h0);
        wr(8'hd0, 8'h01, 4'hd);
        sfr_bit_rd_idx_i <= 3'h5;
        #1;
        chk(bdat, 1'b1, "bit read");
        wr(8'hd0, 8'h01, 4'h9);
        model_u.step(6'h00, 8'hfe, 6'h3f, 16'h0);
        #1;
        chk({sw, 7'h0, cfl}, 16'he701, "flags set");
        model_u.step(6'h00, 8'hfe, 6'h2a, 16'h0);
        #1;
        chk(sw, 8'h23, "flags cleared");
        fork
            model_u.step(6'h00, 8'hfe, 6'h30, 16'h0);
            wr(8'hd0, 8'h00, 4'h0);
        join
        #1;
        chk(sw, 8'h01, "byte collision");
        fork
            model_u.step(6'h00, 8'hfe, 6'h3f, 16'h0);
            wr(8'hd0, 8'h00, 4'hf);
        join
        #1;
        chk({sw, 7'h0, cfl}, 16'h4500, "bit collision");
        $display("status test done");
        wr(8'h81, 8'hfe, 4'h0);
        #1;
        chk(padr, 8'hff, "push address");
        model_u.step(6'h08, 8'h0, 6'h0, 16'h0);
        model_u.step(6'h08, 8'h0, 6'h0, 16'h0);
        #1;
        chk({stk, padr}, 16'h0001, "push wrap");
        model_u.step(6'h0c, 8'h0, 6'h0, 16'h0);
        model_u.step(6'h04, 8'h0, 6'h0, 16'h0);
        #1;
        chk(stk, 8'h00, "push over pop");
        $display("stack test done");
        model_u.step(6'h02, 8'h0, 6'h0, 16'h12ff);
        model_u.step(6'h01, 8'h0, 6'h0, 16'h0);
        #1;
        chk(dp, 16'h1300, "pointer increment");
        model_u.step(6'h03, 8'h0, 6'h0, 16'habcd);
        rd(8'h82, 8'hcd);
        rd(8'h83, 8'hab);
        $display("pointer test done");
        for (int bank = 0; bank < 4; bank++) begin
            wr(8'hd0, {3'h0, bank[1:0], 3'h0}, 4'h0);
            for (int r = 0; r < 8; r++) begin
                @(posedge mclk_i);
                reg_idx_i <= r[2:0];
                #1;
                chk(radr, 16'(bank * 8 + r), "bank address");
            end
        end
        $display("bank test done");
        end_sim();
    end
endmodule
`default_nettype wire
